// ### verilog/fpmc_pkg.sv
// Constants and types shared by the page-mode memory host controller
package fpmc_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POWER_PAUSE_NS = 100000;
  localparam int PAUSE_CYC = (POWER_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_PERIOD_NS = 16000000;
  localparam int REFRESH_ROWS = 1024;
  localparam int REFRESH_CYC = REFRESH_PERIOD_NS / REFRESH_ROWS / CLK_PERIOD_NS;
  localparam int PAGE_ROW_PULSE_MAX_NS = 100000;
  localparam int PAGE_LIMIT_CYC = PAGE_ROW_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int PAGE_CYCLE_TIME_NS = 45;
  localparam int PAGE_CYCLE_CYC = (PAGE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PRECHARGE_NS = 50;
  localparam int PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_SPACING_CYC = 3;
  localparam int PAGE_MARGIN_CYC = 4;
  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  // ----------------------------------------------------------------
  // Widths and pin layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int REQ_ADDR_W = 2 * ADDR_W;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_BITS = 8;
  localparam int LANE_PITCH = 9;
  localparam int PIN_W = LANES * LANE_PITCH;
  localparam int STROBES = 4;
  localparam int REF_PEND_W = 4;
  localparam logic [STROBES-1:0] BANK0_RAS = 4'h5;
  localparam logic [STROBES-1:0] BANK1_RAS = 4'hA;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_INIT_WAIT, ST_IDLE, ST_REF_SETUP, ST_REF_HOLD, ST_ROW_ADDR,
    ST_COL_ADDR, ST_COL_SETUP, ST_COL_LOW, ST_PAGE_OPEN, ST_PRECHARGE
  } fpmc_state_type;
endpackage

// ### verilog/fpmc_pace_if.sv
// Pacing signals from the refresh divider and pause timer to the sequencer
`timescale 1ns/10ps
interface fpmc_pace_if;
  logic refresh_tick;
  logic pause_done;
  modport pacer (output refresh_tick, output pause_done);
  modport ctrl (input refresh_tick, input pause_done);
endinterface

// ### verilog/fpmc_pace.sv
// Refresh interval divider and power-up pause timer
`timescale 1ns/10ps
module fpmc_pace
  import fpmc_pkg::*;
#(
  parameter int REFRESH_CYC_P = REFRESH_CYC,
  parameter int PAUSE_CYC_P = PAUSE_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  fpmc_pace_if.pacer pace
);
  localparam int REF_W = $clog2(REFRESH_CYC_P + 1);
  localparam int PAUSE_W = $clog2(PAUSE_CYC_P + 1);

  if (REFRESH_CYC_P < 2 || PAUSE_CYC_P < 1)
  begin : g_bad_params
    $error("fpmc_pace: refresh interval or pause too short");
  end

  typedef struct packed {
    logic [REF_W-1:0] ref_cnt;
    logic [PAUSE_W-1:0] pause_cnt;
    logic tick;
    logic done;
  } fpmc_pace_state_type;

  fpmc_pace_state_type state;
  fpmc_pace_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    // One-cycle enable every refresh interval
    if (state.ref_cnt == '0)
    begin
      next_state.ref_cnt = REF_W'(REFRESH_CYC_P - 1);
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.ref_cnt = state.ref_cnt - 1'b1;
    end
    if (!state.done)
    begin
      if (state.pause_cnt == PAUSE_W'(PAUSE_CYC_P - 1))
      begin
        next_state.done = 1'b1;
      end
      else
      begin
        next_state.pause_cnt = state.pause_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pace.refresh_tick = state.tick;
  assign pace.pause_done = state.done;
endmodule

// ### verilog/fpmc_host.sv
// Host controller driving a two-bank page-mode memory module by its pins
// Overview of operation
// - Two banks; a bank is chosen only by its own row strobes.
// - Each column strobe gates one byte lane; no parity stored.
// - Page read: first cycle row and column, then new columns only.
// - Page write: same sequence with write enable low, data per column.
// - Column cycles within a page at least 40 or 45 ns apart.
// - Row strobe low no longer than 100K ns in a page burst.
// - Read ends with write enable held past column strobe rise.
// - Refresh by row strobe with row address, or column-first refresh.
// - Row-only refresh: column strobes high, data bus floated.
// - Column-first refresh: column strobe before row strobe, write high.
// - 1024 refresh cycles in every 16 ms.
// - Ten-bit row and column addresses share the address pins.
// - Row strobe high means standby: data bus floated.
// - After power-up wait 100 us, then 8 refreshes before use.
`timescale 1ns/10ps
module fpmc_host
  import fpmc_pkg::*;
#(
  parameter int REFRESH_CYC_P = REFRESH_CYC,
  parameter int PAUSE_CYC_P = PAUSE_CYC,
  parameter int PAGE_LIMIT_CYC_P = PAGE_LIMIT_CYC
)
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic REFRESH_ROW_ONLY,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_BANK,
  input wire logic [REQ_ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic [LANES-1:0] REQ_BE,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DATA_W-1:0] RD_DATA,
  output logic [STROBES-1:0] ROW_STROBE_N,
  output logic [STROBES-1:0] COLUMN_STROBE_N,
  output logic WRITE_EN_N,
  output logic [ADDR_W-1:0] MUX_ADDR,
  input wire logic [PIN_W-1:0] DQ_IN,
  output logic [PIN_W-1:0] DQ_OUT,
  output logic [PIN_W-1:0] DQ_OE
);
  localparam int PAGE_W = $clog2(PAGE_LIMIT_CYC_P + 1);
  localparam logic [PAGE_W-1:0] PAGE_CLOSE_AT = PAGE_W'(PAGE_LIMIT_CYC_P - PAGE_MARGIN_CYC);

  if (PAGE_LIMIT_CYC_P <= 2 * PAGE_MARGIN_CYC || COL_SPACING_CYC < PAGE_CYCLE_CYC
      || PRECHARGE_CYC < 1 || PRECHARGE_CYC > 15)
  begin : g_bad_params
    $error("fpmc_host: page limit or timing counts out of range");
  end

  typedef struct packed {
    fpmc_state_type st;
    logic [STROBES-1:0] ras_n;
    logic [STROBES-1:0] cas_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [PIN_W-1:0] dq_out;
    logic [PIN_W-1:0] dq_oe;
    logic req_ready;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic bank;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic write;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] wdata;
    logic have_req;
    logic [PAGE_W-1:0] page_cnt;
    logic [REF_PEND_W-1:0] ref_pend;
    logic [3:0] init_left;
    logic [ADDR_W-1:0] ref_row;
    logic [3:0] pre_cnt;
  } fpmc_host_state_type;

  localparam fpmc_host_state_type RESET_STATE = '{st: ST_INIT_WAIT, ras_n: '1, cas_n: '1,
    we_n: 1'b1, init_left: INIT_REFRESHES, default: '0};

  fpmc_host_state_type state;
  fpmc_host_state_type next_state;
  fpmc_pace_if pace ();

  fpmc_pace #(
    .REFRESH_CYC_P(REFRESH_CYC_P),
    .PAUSE_CYC_P(PAUSE_CYC_P)
  ) u_pace (
    .clk_sys(CLK_SYS),
    .nrst(NRST),
    .pace(pace.pacer)
  );

  // ----------------------------------------------------------------
  // Byte lanes onto the gapped data pins
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_gather;
  logic [PIN_W-1:0] wr_pins;
  logic [PIN_W-1:0] data_pin_mask;

  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    assign rd_gather[g*LANE_BITS +: LANE_BITS] = DQ_IN[g*LANE_PITCH +: LANE_BITS];
    assign wr_pins[g*LANE_PITCH +: LANE_BITS] = state.wdata[g*LANE_BITS +: LANE_BITS];
    assign wr_pins[g*LANE_PITCH + LANE_BITS] = 1'b0;
    assign data_pin_mask[g*LANE_PITCH +: LANE_BITS] = {LANE_BITS{1'b1}};
    assign data_pin_mask[g*LANE_PITCH + LANE_BITS] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic accept;
  logic ref_done;
  logic page_hit;

  assign accept = state.req_ready && REQ_VALID;
  assign ref_done = (state.st == ST_REF_HOLD) && (state.init_left == '0);
  assign page_hit = (REQ_BANK == state.bank) && (REQ_WRITE == state.write)
    && (REQ_ADDR[REQ_ADDR_W-1:ADDR_W] == state.row);

  always_comb
  begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    // Refresh debt: a tick in the serving cycle is kept
    if (pace.refresh_tick && !ref_done && state.ref_pend != '1)
    begin
      next_state.ref_pend = state.ref_pend + 1'b1;
    end
    else if (!pace.refresh_tick && ref_done)
    begin
      next_state.ref_pend = state.ref_pend - 1'b1;
    end
    if (state.ras_n != '1)
    begin
      next_state.page_cnt = state.page_cnt + 1'b1;
    end
    if (accept)
    begin
      next_state.bank = REQ_BANK;
      next_state.row = REQ_ADDR[REQ_ADDR_W-1:ADDR_W];
      next_state.col = REQ_ADDR[ADDR_W-1:0];
      next_state.write = REQ_WRITE;
      next_state.be = REQ_BE;
      next_state.wdata = REQ_WDATA;
    end
    unique case (state.st)
      ST_INIT_WAIT:
      begin
        if (pace.pause_done)
        begin
          next_state.st = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (accept)
        begin
          next_state.addr = REQ_ADDR[REQ_ADDR_W-1:ADDR_W];
          next_state.st = ST_ROW_ADDR;
        end
        else if (state.init_left != '0 || state.ref_pend != '0)
        begin
          if (REFRESH_ROW_ONLY)
          begin
            next_state.addr = state.ref_row;
          end
          else
          begin
            next_state.cas_n = '0;
          end
          next_state.we_n = 1'b1;
          next_state.st = ST_REF_SETUP;
        end
      end
      ST_REF_SETUP:
      begin
        next_state.ras_n = '0;
        next_state.st = ST_REF_HOLD;
      end
      ST_REF_HOLD:
      begin
        next_state.ras_n = '1;
        next_state.cas_n = '1;
        if (state.cas_n == '1)
        begin
          next_state.ref_row = state.ref_row + 1'b1;
        end
        if (state.init_left != '0)
        begin
          next_state.init_left = state.init_left - 1'b1;
        end
        next_state.pre_cnt = 4'(PRECHARGE_CYC);
        next_state.st = ST_PRECHARGE;
      end
      ST_ROW_ADDR:
      begin
        next_state.ras_n = ~(state.bank ? BANK1_RAS : BANK0_RAS);
        next_state.page_cnt = '0;
        next_state.st = ST_COL_ADDR;
      end
      ST_COL_ADDR:
      begin
        next_state.addr = state.col;
        next_state.we_n = ~state.write;
        next_state.dq_out = wr_pins;
        next_state.dq_oe = state.write ? data_pin_mask : '0;
        next_state.st = ST_COL_SETUP;
      end
      ST_COL_SETUP:
      begin
        next_state.cas_n = state.write ? ~state.be : '0;
        next_state.st = ST_COL_LOW;
      end
      ST_COL_LOW:
      begin
        next_state.cas_n = '1;
        next_state.dq_oe = '0;
        if (!state.write)
        begin
          next_state.rd_valid = 1'b1;
          next_state.rd_data = rd_gather;
        end
        next_state.st = ST_PAGE_OPEN;
      end
      ST_PAGE_OPEN:
      begin
        if (accept && page_hit)
        begin
          next_state.st = ST_COL_ADDR;
        end
        else if (accept || state.ref_pend != '0 || state.page_cnt >= PAGE_CLOSE_AT)
        begin
          next_state.have_req = accept;
          next_state.ras_n = '1;
          next_state.we_n = 1'b1;
          next_state.page_cnt = '0;
          next_state.pre_cnt = 4'(PRECHARGE_CYC);
          next_state.st = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE:
      begin
        if (state.pre_cnt > 4'h1)
        begin
          next_state.pre_cnt = state.pre_cnt - 1'b1;
        end
        else if (state.have_req)
        begin
          next_state.have_req = 1'b0;
          next_state.addr = state.row;
          next_state.st = ST_ROW_ADDR;
        end
        else
        begin
          next_state.st = ST_IDLE;
        end
      end
      default:
      begin
        next_state = RESET_STATE;
        next_state.st = ST_IDLE;
      end
    endcase
    next_state.req_ready = (next_state.st == ST_IDLE || next_state.st == ST_PAGE_OPEN)
      && next_state.init_left == '0 && next_state.ref_pend == '0
      && next_state.page_cnt < PAGE_CLOSE_AT;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state <= RESET_STATE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign REQ_READY = state.req_ready;
  assign RD_VALID = state.rd_valid;
  assign RD_DATA = state.rd_data;
  assign ROW_STROBE_N = state.ras_n;
  assign COLUMN_STROBE_N = state.cas_n;
  assign WRITE_EN_N = state.we_n;
  assign MUX_ADDR = state.addr;
  assign DQ_OUT = state.dq_out;
  assign DQ_OE = state.dq_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic cas_any_low;
  logic cas_all_low;
  logic ras_all_low;
  logic [PAGE_W:0] ras_run;

  assign cas_any_low = state.cas_n != '1;
  assign cas_all_low = state.cas_n == '0;
  assign ras_all_low = state.ras_n == '0;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ras_run <= '0;
    end
    else if (state.ras_n == '1)
    begin
      ras_run <= '0;
    end
    else if (ras_run != '1)
    begin
      ras_run <= ras_run + 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  sequence s_cas_pulse;
    cas_any_low ##1 !cas_any_low;
  endsequence
  sequence s_row_open;
    state.st == ST_ROW_ADDR ##1 state.st == ST_COL_ADDR;
  endsequence

  a_column_spacing: assert property (s_cas_pulse |=> !cas_any_low)
    else $error("column strobe precharged for less than two cycles");
  a_page_limit: assert property (ras_run <= (PAGE_W + 1)'(PAGE_LIMIT_CYC_P))
    else $error("row strobe held low past the page limit");
  a_read_capture: assert property ((state.st == ST_COL_LOW && state.we_n)
    |=> state.rd_valid && state.rd_data == $past(rd_gather) && state.cas_n == '1)
    else $error("read data not captured at column strobe rise");
  a_write_lanes: assert property ((state.st == ST_COL_LOW && !state.we_n)
    |-> state.cas_n == ~state.be && state.dq_oe == data_pin_mask && state.dq_out == wr_pins)
    else $error("write lanes or data do not match the request");
  a_read_hold: assert property ((cas_any_low && state.we_n) |=> state.we_n)
    else $error("write enable fell during a read column pulse");
  a_row_address: assert property (s_row_open
    |-> state.addr == state.row && state.cas_n == '1
    && state.ras_n == ~(state.bank ? BANK1_RAS : BANK0_RAS))
    else $error("row strobe fell without the row address or on the wrong bank");
  a_cbr_order: assert property ((ras_all_low && $past(state.ras_n) == '1 && cas_all_low)
    |-> $past(cas_all_low) && state.we_n && state.dq_oe == '0)
    else $error("column-first refresh out of order");
  a_ror_float: assert property ((ras_all_low && state.cas_n == '1)
    |-> state.dq_oe == '0 && state.addr == state.ref_row)
    else $error("row-only refresh without refresh row or with bus driven");
  a_standby_float: assert property (state.ras_n == '1 |-> state.dq_oe == '0)
    else $error("data bus driven in standby");
  a_init_quiet: assert property (state.init_left != '0 |-> !state.req_ready)
    else $error("requests accepted before initial refreshes");
  a_refresh_serve: assert property ((state.st == ST_IDLE && state.ref_pend != '0
    && !state.req_ready) |=> state.st == ST_REF_SETUP ##2 state.st == ST_PRECHARGE)
    else $error("pending refresh not served");
  a_lane_gaps: assert property ((state.dq_oe & ~data_pin_mask) == '0)
    else $error("gap pin driven");
endmodule

// ### tb/fpmc_mem_model.sv
// Behavioural model of the two-bank page-mode memory module
`timescale 1ns/10ps
module fpmc_mem_model
  import fpmc_pkg::*;
(
  input wire logic [STROBES-1:0] row_strobe_n,
  input wire logic [STROBES-1:0] column_strobe_n,
  input wire logic write_en_n,
  input wire logic [ADDR_W-1:0] mux_addr,
  input wire logic [PIN_W-1:0] dq_out,
  input wire logic [PIN_W-1:0] dq_oe,
  output logic [PIN_W-1:0] dq_in,
  output int refreshes,
  output int row_only_count,
  output int column_first_count
);
  logic [DATA_W-1:0] mem [int];
  logic [STROBES-1:0] ras_q = 4'hF;
  logic [STROBES-1:0] cas_q = 4'hF;
  logic [ADDR_W-1:0] row = 10'h000;
  logic bank = 1'h0;
  logic refresh_row = 1'h0;
  logic out_on = 1'h0;
  logic [DATA_W-1:0] word = 32'h0000_0000;
  int key;
  initial
  begin
    refreshes = 0;
    row_only_count = 0;
    column_first_count = 0;
  end
  // ----------------------------------------------------------------
  // Row strobe edges
  // ----------------------------------------------------------------
  always @(row_strobe_n)
  begin
    if (ras_q == 4'hF && row_strobe_n != 4'hF)
    begin
      row = mux_addr;
      bank = row_strobe_n[0];
      refresh_row = (row_strobe_n == 4'h0);
      if (refresh_row)
      begin
        refreshes++;
        if (column_strobe_n == 4'hF)
          row_only_count++;
        else if (write_en_n)
          column_first_count++;
      end
    end
    if (row_strobe_n == 4'hF)
      out_on = 1'h0;
    ras_q = row_strobe_n;
  end
  // ----------------------------------------------------------------
  // Column strobe edges
  // ----------------------------------------------------------------
  always @(column_strobe_n)
  begin
    if (cas_q == 4'hF && column_strobe_n != 4'hF && ras_q != 4'hF && !refresh_row)
    begin
      key = int'({bank, row, mux_addr});
      word = mem.exists(key) ? mem[key] : 32'h0000_0000;
      if (!write_en_n)
      begin
        for (int i = 0; i < LANES; i++)
          if (!column_strobe_n[i] && dq_oe[i*LANE_PITCH])
            word[i*LANE_BITS +: LANE_BITS] = dq_out[i*LANE_PITCH +: LANE_BITS];
        mem[key] = word;
      end
      else
        out_on = (refreshes >= 8);
    end
    if (column_strobe_n == 4'hF)
      out_on = 1'h0;
    cas_q = column_strobe_n;
  end
  // Floated lines show the inverse of the last word
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      dq_in[i*LANE_PITCH +: LANE_BITS] = out_on ? word[i*LANE_BITS +: LANE_BITS] :
        ~word[i*LANE_BITS +: LANE_BITS];
      dq_in[i*LANE_PITCH+LANE_BITS] = ~out_on;
    end
  end
endmodule

// ### tb/fpmc_host_tb.sv
// Self-checking bench for the page-mode memory host controller
`timescale 1ns/10ps
module fpmc_host_tb import fpmc_pkg::*;;
  localparam int RCYC = 20;
  localparam int PCYC = 10;
  localparam int LCYC = 20;
  logic CLK_SYS = 1'h0;
  logic NRST = 1'h0;
  logic REFRESH_ROW_ONLY = 1'h0;
  logic REQ_VALID = 1'h0;
  logic REQ_WRITE = 1'h0;
  logic REQ_BANK = 1'h0;
  logic [REQ_ADDR_W-1:0] REQ_ADDR = 20'h0_0000;
  logic [DATA_W-1:0] REQ_WDATA = 32'h0000_0000;
  logic [LANES-1:0] REQ_BE = 4'h0;
  logic REQ_READY, RD_VALID, WRITE_EN_N;
  logic [DATA_W-1:0] RD_DATA;
  logic [STROBES-1:0] ROW_STROBE_N, COLUMN_STROBE_N;
  logic [ADDR_W-1:0] MUX_ADDR;
  logic [PIN_W-1:0] DQ_IN, DQ_OUT, DQ_OE;
  int n_mismatch = 0, tests_run = 0, cyc = 0, rel = 0, low_cnt = 0, since_cf = 0;
  int refreshes, row_only_count, column_first_count;
  logic [DATA_W-1:0] ref_mem [int];
  logic [STROBES-1:0] ras_q = 4'hF, cas_q = 4'hF;
  logic we_fall = 1'h1;
  logic [11:0] last_req = 12'h000;
  always #50 CLK_SYS = ~CLK_SYS;
  fpmc_host #(.REFRESH_CYC_P(RCYC), .PAUSE_CYC_P(PCYC), .PAGE_LIMIT_CYC_P(LCYC)) u_fpmc_host (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .REFRESH_ROW_ONLY(REFRESH_ROW_ONLY),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_BANK(REQ_BANK), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_BE(REQ_BE), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .ROW_STROBE_N(ROW_STROBE_N), .COLUMN_STROBE_N(COLUMN_STROBE_N),
    .WRITE_EN_N(WRITE_EN_N), .MUX_ADDR(MUX_ADDR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
    .DQ_OE(DQ_OE));
  fpmc_mem_model u_fpmc_mem_model (.row_strobe_n(ROW_STROBE_N),
    .column_strobe_n(COLUMN_STROBE_N), .write_en_n(WRITE_EN_N), .mux_addr(MUX_ADDR),
    .dq_out(DQ_OUT), .dq_oe(DQ_OE), .dq_in(DQ_IN), .refreshes(refreshes),
    .row_only_count(row_only_count), .column_first_count(column_first_count));
  // ----------------------------------------------------------------
  // Compare and close
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Pin monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  always @(posedge CLK_SYS)
  begin
    if (NRST)
    begin
      rel++;
      since_cf++;
      check({DQ_OE[35], DQ_OE[26], DQ_OE[17], DQ_OE[8]}, 4'h0);
      if (ROW_STROBE_N == 4'hF)
        check(DQ_OE, 36'h0_0000_0000);
      low_cnt = (ROW_STROBE_N == 4'hF) ? 0 : low_cnt + 1;
      check(low_cnt <= LCYC, 1'h1);
      if (ras_q == 4'hF && ROW_STROBE_N == 4'h0)
      begin
        check(DQ_OE, 36'h0_0000_0000);
        if (COLUMN_STROBE_N != 4'hF)
          check({cas_q, WRITE_EN_N}, 5'h01);
      end
      else if (ras_q == 4'hF && ROW_STROBE_N != 4'hF)
      begin
        check(ROW_STROBE_N == ~BANK0_RAS || ROW_STROBE_N == ~BANK1_RAS, 1'h1);
        check(refreshes >= 8 && rel > PCYC, 1'h1);
      end
      if (ROW_STROBE_N != 4'hF && ROW_STROBE_N != 4'h0)
      begin
        if (cas_q == 4'hF && COLUMN_STROBE_N != 4'hF)
        begin
          check(since_cf > PAGE_CYCLE_CYC, 1'h1);
          since_cf = 0;
          we_fall = WRITE_EN_N;
        end
        if (cas_q != 4'hF && COLUMN_STROBE_N == 4'hF)
          check(WRITE_EN_N, we_fall);
      end
    end
    ras_q = ROW_STROBE_N;
    cas_q = COLUMN_STROBE_N;
  end
  // ----------------------------------------------------------------
  // Request driver with reference memory
  // ----------------------------------------------------------------
  task automatic do_req(input logic wr, input logic bk, input logic [9:0] row,
    input logic [9:0] col, input logic [31:0] wd, input logic [3:0] be);
    int n;
    int key;
    int exp_lat;
    logic [31:0] w;
    key = int'({bk, row, col});
    w = ref_mem.exists(key) ? ref_mem[key] : 32'h0000_0000;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'h1;
    REQ_WRITE <= wr;
    REQ_BANK <= bk;
    REQ_ADDR <= {row, col};
    REQ_WDATA <= wd;
    REQ_BE <= be;
    REFRESH_ROW_ONLY <= 1'($urandom);
    n = 0;
    @(posedge CLK_SYS);
    while (REQ_READY !== 1'h1 && n < 3000)
    begin
      @(posedge CLK_SYS);
      n++;
    end
    // Latency: new row from idle, page hit, or page miss with precharge
    exp_lat = (ROW_STROBE_N == 4'hF) ? 5 : (last_req == {wr, bk, row}) ? 4 : 6;
    last_req = {wr, bk, row};
    REQ_VALID <= 1'h0;
    if (wr)
    begin
      for (int b = 0; b < LANES; b++)
        if (be[b])
          w[b*8 +: 8] = wd[b*8 +: 8];
      ref_mem[key] = w;
    end
    else
    begin
      n = 0;
      while (RD_VALID !== 1'h1 && n < 8)
      begin
        @(posedge CLK_SYS);
        n++;
      end
      check(RD_DATA, w);
      check(n, exp_lat);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int seed;
    seed = $urandom(67);
    repeat (2) @(posedge CLK_SYS);
    check({ROW_STROBE_N, COLUMN_STROBE_N, WRITE_EN_N, DQ_OE, REQ_READY},
      {8'hFF, 1'h1, 36'h0_0000_0000, 1'h0});
    NRST <= 1'h1;
    for (int i = 0; i < 150; i++)
    begin
      do_req(1'($urandom), 1'($urandom), ($urandom % 2) ? 10'h3FF : 10'h000,
        10'($urandom % 4) ^ {10{1'($urandom)}}, 32'($urandom), 4'($urandom));
      if ($urandom % 10 == 0)
        repeat (30) @(posedge CLK_SYS);
    end
    repeat (50) @(posedge CLK_SYS);
    check(refreshes + 3 >= rel / RCYC, 1'h1);
    check(row_only_count > 0 && column_first_count > 0, 1'h1);
    end_of_test();
  end
endmodule
